// >>> ldcr_pkg.sv
// Package: register map, field layout, reset values and carrier types of the LCD drive control block
package ldcr_pkg;

  // ==========================================
  // Register map (byte addresses)
  localparam int unsigned AXI_AW      = 4;
  localparam logic [3:0]  ADDR_MAIN   = 4'h0;
  localparam logic [3:0]  ADDR_WAVE   = 4'h4;
  localparam logic [3:0]  ADDR_CKSTP  = 4'h8;
  localparam logic [3:0]  ADDR_STATUS = 4'hc;

  // ==========================================
  // Field positions
  localparam int unsigned MAIN_GATE_BIT = 6;
  localparam int unsigned MAIN_ACT_BIT  = 5;
  localparam int unsigned MAIN_SHOW_BIT = 4;
  localparam int unsigned WAVE_SEL_BIT  = 7;
  localparam int unsigned STBY_BIT      = 0;

  // ==========================================
  // Reset values and fixed read bits
  localparam logic [7:0] MAIN_RST       = 8'h80;
  localparam logic [7:0] WAVE_RST       = 8'h60;
  localparam logic [7:0] CKSTP_RST      = 8'hff;
  localparam logic [7:0] MAIN_ONES      = 8'h80;
  localparam logic [7:0] WAVE_ONES      = 8'h60;
  localparam logic [7:0] CKSTP_ONES     = 8'hf0;

  // ==========================================
  // Frame timing: operating ticks per frame
  localparam int unsigned FRAME_W       = 10;
  localparam logic [9:0]  SUB_FRAME_DIV = 10'h100;
  localparam logic [9:0]  SYS_FRAME_DIV = 10'h200;
  localparam int unsigned SYS_DIV_W     = 8;
  localparam int unsigned SUB_DIV_W     = 2;

  // ==========================================
  // Charge/discharge pulse codes, connected ticks per 32-tick period
  localparam int unsigned PULSE_PH_W     = 5;
  localparam logic [3:0]  CDS_FIXED_HIGH = 4'h0;
  localparam logic [3:0]  CDS_FIXED_LOW  = 4'h7;
  localparam logic [4:0]  PULSE_SIXTEENTH = 5'h02;
  localparam logic [4:0]  PULSE_THIRTY2ND = 5'h01;

  // ==========================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================
  // Carrier types
  typedef struct packed {
    logic       power_gate;  // Drive supply request
    logic       activate;    // Controller run
    logic       show_data;   // Memory data versus blank
    logic [3:0] clk_sel;     // Frame clock select
    logic       wave_b;      // B waveform
    logic [3:0] pulse_sel;   // Pulse duty code
    logic [3:0] stop_n;      // Module standby bits, low = standby
  } ldcr_regs_t;

  typedef struct packed {
    logic power_on;       // LCD drive supply on
    logic show_data;      // Panel shows memory data
    logic waveform_b;     // B drive waveform
    logic frame_tick;     // One pulse per frame
    logic frame_phase;    // Toggles each frame
    logic split_connect;  // Split resistance connected
    logic module_standby; // Module in standby
  } ldcr_drive_t;

  typedef struct packed {
    ldcr_regs_t          regs;
    logic                aw_got;
    logic [3:0]          aw_addr;
    logic                w_got;
    logic [7:0]          wdata;
    logic                wstrb0;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [7:0]          rdata;
    logic [FRAME_W-1:0]  frame_cnt;
    logic                frame_tick;
    logic                frame_phase;
    logic                power_on;
    logic                show_data;
  } ldcr_state_t;

  localparam ldcr_regs_t REGS_RST = '{
    power_gate: MAIN_RST[6], activate: MAIN_RST[5], show_data: MAIN_RST[4],
    clk_sel: MAIN_RST[3:0], wave_b: WAVE_RST[7], pulse_sel: WAVE_RST[3:0],
    stop_n: CKSTP_RST[3:0]};

  localparam ldcr_state_t ST_RST = '{regs: REGS_RST, default: '0};

endpackage

// >>> ldcr_tick_div.sv
// Module: binary clock-enable divider, one tick per 2**sel steps
`timescale 1ns/10ps
module ldcr_tick_div
  import ldcr_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned SEL_W = 4
) (
  input  wire logic             clock,  // System clock
  input  wire logic             arst_n, // Async reset, active low
  input  wire logic             clear,  // Hold count at zero
  input  wire logic             step,   // One source clock edge
  input  wire logic [SEL_W-1:0] sel,    // Divide by 2**sel
  output logic                  tick    // One-cycle divided pulse
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;  // Step counter
    logic             tick; // Registered tick
  } ldcr_div_state_t;

  ldcr_div_state_t st;      // Current state
  ldcr_div_state_t next_st; // Next state
  logic [WIDTH-1:0] mask;   // Low bits that must be all ones

  // ==========================================
  // Next state
  always_comb begin
    next_st = st;
    mask = ~({WIDTH{1'b1}} << sel);
    next_st.tick = 1'b0;
    if (clear) begin
      // Restart so that the first period after release is whole
      next_st.cnt = '0;
    end else if (step) begin
      next_st.cnt = st.cnt + 1'b1;
      next_st.tick = ((st.cnt & mask) == mask);
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule

// >>> ldcr_duty_pulse.sv
// Module: charge/discharge pulse generator for the bias split resistance
`timescale 1ns/10ps
module ldcr_duty_pulse
  import ldcr_pkg::*;
(
  input  wire logic       clock,   // System clock
  input  wire logic       arst_n,  // Async reset, active low
  input  wire logic       clear,   // Controller halted
  input  wire logic       step,    // Operating clock tick
  input  wire logic [3:0] code,    // Duty code
  output logic            connect  // Resistance connected
);

  typedef struct packed {
    logic [PULSE_PH_W-1:0] phase;   // Position in pulse period
    logic                  connect; // Registered output
  } ldcr_pulse_state_t;

  ldcr_pulse_state_t st;      // Current state
  ldcr_pulse_state_t next_st; // Next state

  // ==========================================
  // Next state: connected while phase below the duty share
  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.phase = '0;
      next_st.connect = 1'b0;
    end else begin
      if (step) begin
        next_st.phase = st.phase + 1'b1;
      end
      if (code == CDS_FIXED_HIGH) begin
        next_st.connect = 1'b1;
      end else if (code == CDS_FIXED_LOW) begin
        // Permanently open; bias must come from outside
        next_st.connect = 1'b0;
      end else if (code[3]) begin
        next_st.connect = code[2] ? (st.phase < PULSE_THIRTY2ND) : (st.phase < PULSE_SIXTEENTH);
      end else begin
        // Eighths: Tc over Tw of a 32-tick period
        next_st.connect = (st.phase < {code[2:0], 2'h0});
      end
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign connect = st.connect;

endmodule

// >>> ldcr_lcd_drive_control.sv
// Module: LCD drive control registers, frame clock and drive gating behind AXI4-Lite
`timescale 1ns/10ps

module ldcr_lcd_drive_control
  import ldcr_pkg::*;
(
  input  wire logic              clock,           // System clock, 25 MHz
  input  wire logic              arst_n,          // Async reset, active low
  input  wire logic              awvalid,         // Write address valid
  output logic                   awready,         // Write address ready
  input  wire logic [AXI_AW-1:0] awaddr,          // Write byte address
  input  wire logic              wvalid,          // Write data valid
  output logic                   wready,          // Write data ready
  input  wire logic [31:0]       wdata,           // Write data
  input  wire logic [3:0]        wstrb,           // Write byte strobes
  output logic                   bvalid,          // Write response valid
  input  wire logic              bready,          // Write response ready
  output logic [1:0]             bresp,           // Write response
  input  wire logic              arvalid,         // Read address valid
  output logic                   arready,         // Read address ready
  input  wire logic [AXI_AW-1:0] araddr,          // Read byte address
  output logic                   rvalid,          // Read data valid
  input  wire logic              rready,          // Read data ready
  output logic [31:0]            rdata,           // Read data
  output logic [1:0]             rresp,           // Read response
  input  wire logic              sub_tick,        // Sub-clock edge pulse
  input  wire logic              chip_standby,    // Chip in standby mode
  input  wire logic              sys_clock_halted, // Sub/watch/subsleep mode
  input  wire logic              duty_one_third,  // One-third duty in use
  output ldcr_drive_t            drive,           // Panel drive controls
  output logic [2:0]             other_stop_n     // Other modules' standby bits
);

  // ==========================================
  // Declarations
  ldcr_state_t          st;           // Current state
  ldcr_state_t          next_st;      // Next state
  logic                 running;      // Controller may operate
  logic                 sys_tick;     // Divided system clock
  logic                 sub_div_tick; // Divided sub-clock
  logic                 op_tick;      // Selected operating tick
  logic [3:0]           sys_sel;      // System divider select
  logic [1:0]           sub_sel;      // Sub divider select
  logic [FRAME_W-1:0]   frame_base;   // Ticks per frame
  logic [FRAME_W-1:0]   term_m1;      // Last count of a frame
  logic                 split_conn;   // From pulse generator
  logic                 wr_fire;      // Write both halves held
  logic [7:0]           rd_byte;      // Read mux
  logic                 rd_hit;       // Read address mapped

  // ==========================================
  // Run condition: standby or halt keeps everything still
  assign running = st.regs.activate & st.regs.stop_n[STBY_BIT] & ~chip_standby;

  // ==========================================
  // Frame clock selection
  always_comb begin
    // System path divides by 2, 4 .. 256
    sys_sel = {1'b0, st.regs.clk_sel[2:0]} + 4'h1;
    // Sub path: 00 none, 01 half, 1x quarter
    sub_sel = st.regs.clk_sel[1] ? 2'h2 : {1'b0, st.regs.clk_sel[0]};
    if (st.regs.clk_sel[3]) begin
      // No system clock in low-power modes, so no display
      op_tick = sys_tick & ~sys_clock_halted;
      frame_base = SYS_FRAME_DIV;
    end else begin
      op_tick = sub_div_tick;
      frame_base = SUB_FRAME_DIV;
    end
    // Three quarters of the ticks gives four thirds the rate
    term_m1 = (duty_one_third ? frame_base - (frame_base >> 2) : frame_base) - 10'h001;
  end

  ldcr_tick_div #(
    .WIDTH (SYS_DIV_W),
    .SEL_W (4)
  ) u_sys_div (
    .clock  (clock),
    .arst_n (arst_n),
    .clear  (~running),
    .step   (1'b1),
    .sel    (sys_sel),
    .tick   (sys_tick)
  );

  ldcr_tick_div #(
    .WIDTH (SUB_DIV_W),
    .SEL_W (2)
  ) u_sub_div (
    .clock  (clock),
    .arst_n (arst_n),
    .clear  (~running),
    .step   (sub_tick),
    .sel    (sub_sel),
    .tick   (sub_div_tick)
  );

  ldcr_duty_pulse u_pulse (
    .clock   (clock),
    .arst_n  (arst_n),
    .clear   (~running),
    .step    (op_tick),
    .code    (st.regs.pulse_sel),
    .connect (split_conn)
  );

  // ==========================================
  // Read mux with fixed bits forced
  always_comb begin
    rd_hit = 1'b1;
    unique case (araddr)
      ADDR_MAIN: begin
        // Top bit fixed at one
        rd_byte = MAIN_ONES | {1'b0, st.regs.power_gate, st.regs.activate,
                               st.regs.show_data, st.regs.clk_sel};
      end
      ADDR_WAVE: begin
        // Bits 6:5 one, bit 4 zero
        rd_byte = WAVE_ONES | {st.regs.wave_b, 3'h0, st.regs.pulse_sel};
      end
      ADDR_CKSTP: begin
        rd_byte = CKSTP_ONES | {4'h0, st.regs.stop_n};
      end
      ADDR_STATUS: begin
        rd_byte = {4'h0, split_conn, st.frame_phase, running, st.power_on};
      end
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // ==========================================
  // Next state: bus slave, registers, frame counter
  assign wr_fire = st.aw_got & st.w_got & ~st.bvalid;

  always_comb begin
    next_st = st;
    // Write address and data are taken in either order
    if (awvalid && awready) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = wdata[7:0];
      next_st.wstrb0 = wstrb[0];
    end
    if (wr_fire) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      unique case (st.aw_addr)
        ADDR_MAIN: begin
          // Top bit has no storage, writes to it vanish
          if (st.wstrb0) begin
            next_st.regs.power_gate = st.wdata[MAIN_GATE_BIT];
            next_st.regs.activate = st.wdata[MAIN_ACT_BIT];
            next_st.regs.show_data = st.wdata[MAIN_SHOW_BIT];
            next_st.regs.clk_sel = st.wdata[3:0];
          end
        end
        ADDR_WAVE: begin
          // Bits 6:4 are not stored
          if (st.wstrb0) begin
            next_st.regs.wave_b = st.wdata[WAVE_SEL_BIT];
            next_st.regs.pulse_sel = st.wdata[3:0];
          end
        end
        ADDR_CKSTP: begin
          if (st.wstrb0) begin
            next_st.regs.stop_n = st.wdata[3:0];
          end
        end
        ADDR_STATUS: begin
          // Status is read-only; writes are dropped
        end
        default: begin
          next_st.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    // Read: one edge from address to data
    if (arvalid && arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_byte;
      next_st.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    // Supply only while running and requested
    next_st.power_on = running & st.regs.power_gate;
    // Blank unless display bit set and running
    next_st.show_data = running & st.regs.show_data;
    // Frame counter; halting freezes the picture in blank
    next_st.frame_tick = 1'b0;
    if (!running) begin
      next_st.frame_cnt = '0;
    end else if (op_tick) begin
      if (st.frame_cnt >= term_m1) begin
        next_st.frame_cnt = '0;
        next_st.frame_tick = 1'b1;
        next_st.frame_phase = ~st.frame_phase;
      end else begin
        next_st.frame_cnt = st.frame_cnt + 10'h001;
      end
    end
  end

  // ==========================================
  // State register; reset values are constants
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // Outputs
  assign awready = ~st.aw_got & ~st.bvalid;
  assign wready = ~st.w_got & ~st.bvalid;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = ~st.rvalid;
  assign rvalid = st.rvalid;
  assign rdata = {24'h000000, st.rdata};
  assign rresp = st.rresp;
  assign other_stop_n = st.regs.stop_n[3:1];

  always_comb begin
    drive.power_on = st.power_on;
    drive.show_data = st.show_data;
    drive.waveform_b = st.regs.wave_b;
    drive.frame_tick = st.frame_tick;
    drive.frame_phase = st.frame_phase;
    drive.split_connect = split_conn;
    drive.module_standby = ~st.regs.stop_n[STBY_BIT];
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  sequence s_rd_main;
    arvalid && arready && (araddr == ADDR_MAIN);
  endsequence
  sequence s_rd_wave;
    arvalid && arready && (araddr == ADDR_WAVE);
  endsequence
  sequence s_wr_both;
    st.aw_got && st.w_got && !st.bvalid;
  endsequence

  property p_main_top_one;
    s_rd_main |=> rvalid && rdata[7];
  endproperty
  a_main_top_one: assert property (p_main_top_one) else $error("main top bit not one");

  property p_wave_fixed;
    s_rd_wave |=> rvalid && (rdata[6:4] == 3'h6);
  endproperty
  a_wave_fixed: assert property (p_wave_fixed) else $error("waveform fixed bits wrong");

  property p_power_forced_off;
    (!st.regs.activate || chip_standby || !st.regs.stop_n[STBY_BIT]) |=> !drive.power_on;
  endproperty
  a_power_forced_off: assert property (p_power_forced_off) else $error("supply on while halted");

  property p_power_gate;
    running && st.regs.power_gate |=> drive.power_on;
  endproperty
  a_power_gate: assert property (p_power_gate) else $error("supply off while gated on");

  property p_blank;
    !st.regs.show_data |=> !drive.show_data;
  endproperty
  a_blank: assert property (p_blank) else $error("memory shown while blank");

  property p_frame_len;
    drive.frame_tick |-> (st.frame_cnt == '0) && ($past(st.frame_cnt) >= $past(term_m1));
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame ended early");

  property p_sys_halt;
    running && st.regs.clk_sel[3] && sys_clock_halted && $stable(st.regs.clk_sel) |=> !drive.frame_tick;
  endproperty
  a_sys_halt: assert property (p_sys_halt) else $error("frame ran on halted system clock");

  property p_fixed_duty;
    running && (st.regs.pulse_sel == CDS_FIXED_LOW) |=> !drive.split_connect;
  endproperty
  a_fixed_duty: assert property (p_fixed_duty) else $error("resistance connected at zero duty");

  property p_write_resp;
    s_wr_both |=> bvalid && !awready && !wready;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write not answered");

endmodule

// >>> ldcr_panel_model.sv
// Panel-side model: watches frame pulses and split-resistance duty
`timescale 1ns/10ps
module ldcr_panel_model
  import ldcr_pkg::*;
(
  input  wire logic        clock,  // System clock
  input  wire logic        arst_n, // Async reset, active low
  input  wire ldcr_drive_t drive,  // Drive controls from the block
  output int               frames, // Frame pulses seen
  output int               period, // Cycles between last two frames
  output int               highs   // Connected cycles in last window
);
  int gap; // Cycles since last frame
  int win; // Position in the 64-cycle window
  int acc; // Connected count in window
  // ==========================================
  // Measurement
  // Window of 64 cycles spans two pulse periods when ticks run every cycle
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      {frames, period, highs, gap, win, acc} = '0;
    end else begin
      gap = gap + 1;
      if (drive.frame_tick) begin
        period = gap;
        frames = frames + 1;
        gap = 0;
      end
      acc = acc + drive.split_connect;
      win = win + 1;
      if (win == 64) begin
        highs = acc; // Zero means external bias is needed
        acc = 0;
        win = 0;
      end
    end
  end
endmodule

// >>> ldcr_lcd_drive_control_test.sv
// Testbench: register bus, drive gating, frame timing and pulse duty
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module ldcr_lcd_drive_control_test
  import ldcr_pkg::*;
;
  logic              clock, arst_n;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, rsp;
  logic              sub_tick, chip_standby, sys_clock_halted, duty_one_third;
  ldcr_drive_t       drive;
  logic [2:0]        other_stop_n;
  int                frames, period, highs, checked, bad_count, cycles;
  // Frame cases: {halted, one third, select}
  localparam logic [5:0] FCASE [9] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h10,
                                       6'h08, 6'h09, 6'h18, 6'h20};

  ldcr_lcd_drive_control DUT (.clock(clock), .arst_n(arst_n), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .sub_tick(sub_tick),
    .chip_standby(chip_standby), .sys_clock_halted(sys_clock_halted),
    .duty_one_third(duty_one_third), .drive(drive), .other_stop_n(other_stop_n));
  ldcr_panel_model panel (.clock(clock), .arst_n(arst_n), .drive(drive),
    .frames(frames), .period(period), .highs(highs));

  // ==========================================
  // Expectations
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Cycles per frame with sub_tick high every cycle
  function automatic int exp_period(input logic [3:0] s, input logic t);
    int n;
    n = s[3] ? (512 << (int'(s[2:0]) + 1)) : (256 << (s[1] ? 2 : s[0]));
    return t ? n * 3 / 4 : n;
  endfunction
  // Connected cycles in 64, pulse period 32
  function automatic int exp_highs(input logic [3:0] c);
    if (c == 4'h0) return 64;
    if (c == 4'h7) return 0;
    if (c[3]) return c[2] ? 2 : 4;
    return 8 * c;
  endfunction

  // ==========================================
  // Bus master tasks; readiness is sampled on the falling edge, acted on at the rising
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic ta, tw, ha, hw;
    @(posedge clock);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    bready <= 1'b1;
    ta = 1'b0;
    tw = 1'b0;
    while (!(ta && tw)) begin
      @(negedge clock);
      ha = awvalid & awready;
      hw = wvalid & wready;
      @(posedge clock);
      if (ha) begin
        awvalid <= 1'b0;
        ta = 1'b1;
      end
      if (hw) begin
        wvalid <= 1'b0;
        tw = 1'b1;
      end
    end
    ha = 1'b0;
    while (!ha) begin
      @(negedge clock);
      ha = bvalid;
      hw = (bresp === RESP_OKAY);
      @(posedge clock);
    end
    bready <= 1'b0;
    `CHK("bresp ok", 1'b1, hw)
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    logic h;
    @(posedge clock);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    h = 1'b0;
    while (!h) begin
      @(negedge clock);
      h = arready;
      @(posedge clock);
    end
    arvalid <= 1'b0;
    h = 1'b0;
    while (!h) begin
      @(negedge clock);
      h = rvalid;
      d = rdata[7:0];
      rsp = rresp;
      @(posedge clock);
    end
    rready <= 1'b0;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================
  // Clock, reset and hang guard
  always #20 clock = ~clock;
  initial begin
    {clock, arst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, checked, bad_count, cycles} = '0;
    {chip_standby, sys_clock_halted, duty_one_third} = '0;
    sub_tick = 1'b1; // Sub-clock edge every cycle keeps frames short
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      test_done;
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    logic [7:0]  v;
    logic [31:0] r;
    int          f0;
    @(posedge arst_n);
    rd(ADDR_MAIN, v); `CHK("main rst", MAIN_RST, v)
    rd(ADDR_WAVE, v); `CHK("wave rst", WAVE_RST, v)
    rd(ADDR_CKSTP, v); `CHK("ckstp rst", CKSTP_RST, v)
    `CHK("read resp", RESP_OKAY, rsp)
    rd(4'h2, v); // Unmapped place answers with an error and zero data
    `CHK("unmapped data", 8'h00, v)
    `CHK("unmapped resp", RESP_SLVERR, rsp)
    wr(ADDR_STATUS, 8'hff); // Read-only place, accepted and ignored
    r = 32'h0043b79f;
    for (int i = 0; i < 12; i++) begin
      r = lfsr(r);
      chip_standby <= r[16];
      wr(ADDR_MAIN, r[7:0]);
      wr(ADDR_CKSTP, r[15:8]);
      wr(ADDR_WAVE, r[23:16] & 8'hef); // Bit four never written high
      repeat (2) @(posedge clock);
      rd(ADDR_MAIN, v); `CHK("main", r[7:0] | 8'h80, v)
      rd(ADDR_WAVE, v); `CHK("wave", (r[23:16] | 8'h60) & 8'hef, v)
      rd(ADDR_CKSTP, v); `CHK("ckstp", r[15:8] | 8'hf0, v)
      @(negedge clock);
      `CHK("power", r[6] & r[5] & r[8] & !r[16], drive.power_on)
      `CHK("show", r[4] & r[5] & r[8] & !r[16], drive.show_data)
      `CHK("wave b", r[23], drive.waveform_b)
      `CHK("standby", !r[8], drive.module_standby)
      `CHK("others", r[11:9], other_stop_n)
    end
    chip_standby <= 1'b0;
    wr(ADDR_CKSTP, 8'h0f);
    for (int i = 0; i < 9; i++) begin
      duty_one_third <= FCASE[i][4];
      sys_clock_halted <= FCASE[i][5];
      wr(ADDR_MAIN, {4'h2, FCASE[i][3:0]});
      f0 = frames;
      while (frames < f0 + 3) @(posedge clock);
      `CHK("period", exp_period(FCASE[i][3:0], FCASE[i][4]), period)
      rd(ADDR_STATUS, v);
      `CHK("status", 2'h2, v[1:0])
    end
    sys_clock_halted <= 1'b1;
    wr(ADDR_MAIN, 8'h28);
    // A frame begun under the old select may still be counted at this edge
    @(posedge clock);
    f0 = frames;
    repeat (3000) @(posedge clock);
    `CHK("halted frames", f0, frames)
    sys_clock_halted <= 1'b0;
    duty_one_third <= 1'b0;
    wr(ADDR_MAIN, 8'h20);
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_WAVE, 8'(c) & 8'h0f);
      repeat (140) @(posedge clock);
      `CHK("duty", exp_highs(4'(c)), highs)
    end
    test_done;
  end
endmodule
